//--- hdl/mrfs_rate_mon.v
`timescale 1ns/1ps
`include "mrfs_defs.vh"

module mrfs_rate_mon #(
    parameter LVL_W = `MRFS_LVL_W,
    parameter [LVL_W-1:0] SLIP_LIM = `MRFS_SLIP_LIM,
    parameter [LVL_W-1:0] SLIP_REL = `MRFS_SLIP_REL
) (
    input  wire aclk,
    input  wire aresetn,
    input  wire recenter,
    input  wire in_stb,
    input  wire out_stb,
    output reg  overrun_q,
    output reg  underrun_q
);

    // Signed slip between the two stages, saturating at both ends
    reg  signed [LVL_W-1:0] slip_q;
    reg  signed [LVL_W-1:0] slip_d;
    wire signed [LVL_W-1:0] lim_pos = SLIP_LIM;
    wire signed [LVL_W-1:0] lim_neg = -SLIP_LIM;
    wire signed [LVL_W-1:0] rel_pos = SLIP_REL;
    wire signed [LVL_W-1:0] rel_neg = -SLIP_REL;

    ////////////////////////////////////////////////////////////////////////
    // Slip accumulation; a word in and out together cancel
    always @* begin
        slip_d = slip_q;
        if (recenter) begin
            slip_d = {LVL_W{1'b0}};
        end else if (in_stb && !out_stb && slip_q < lim_pos) begin
            slip_d = slip_q + 1'b1;
        end else if (out_stb && !in_stb && slip_q > lim_neg) begin
            slip_d = slip_q - 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            slip_q <= {LVL_W{1'b0}};
        end else begin
            slip_q <= slip_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Small slip stays inside the band as pointer adjustment; only a
    // large mismatch declares. Release needs a return well inside the
    // band, so a clock hovering at the limit does not chatter.
    always @(posedge aclk) begin
        if (!aresetn || recenter) begin
            overrun_q  <= 1'b0;
            underrun_q <= 1'b0;
        end else begin
            if (slip_q >= lim_pos) begin
                overrun_q <= 1'b1;
            end else if (slip_q <= rel_pos) begin
                overrun_q <= 1'b0;
            end
            if (slip_q <= lim_neg) begin
                underrun_q <= 1'b1;
            end else if (slip_q >= rel_neg) begin
                underrun_q <= 1'b0;
            end
        end
    end

endmodule

//--- hdl/mrfs_top.v
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "mrfs_defs.vh"


module mrfs_top #(
    parameter LVL_W = `MRFS_LVL_W,
    parameter [LVL_W-1:0] SLIP_LIM = `MRFS_SLIP_LIM,
    parameter [LVL_W-1:0] SLIP_REL = `MRFS_SLIP_REL
) (
    input  wire        aclk,
    input  wire        aresetn,
    // Stage strobes, one per pair: 3 rx STM-0, 2 tx STM-0, 1 rx DS3, 0 tx DS3
    input  wire [3:0]  stage_in_stb,
    input  wire [3:0]  stage_out_stb,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Channel interrupt request
    output reg         irq
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode helpers

    // Word index of a byte address; low two bits are ignored
    function [5:0] mrfs_index;
        input [7:0] addr;
        begin
            mrfs_index = addr[7:2];
        end
    endfunction

    // True when the index names a mapped register
    function mrfs_mapped;
        input [5:0] idx;
        begin
            mrfs_mapped = (idx == `MRFS_IDX_COND)  || (idx == `MRFS_IDX_FLAGS) ||
                          (idx == `MRFS_IDX_ENABLE) || (idx == `MRFS_IDX_CTRL);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    wire [3:0] mon_ovr;
    wire [3:0] mon_udr;
    wire [7:0] cond;
    reg  [7:0] cond_prev_q;
    reg  [7:0] flags_q;
    reg  [7:0] flags_d;
    reg  [7:0] enable_q;
    reg        recenter_q;

    reg        aw_hold_q;
    reg  [5:0] aw_idx_q;
    reg        w_hold_q;
    reg  [7:0] w_byte_q;
    reg        w_lane0_q;

    wire       wr_fire;
    wire       rd_fire;
    wire [5:0] rd_idx;
    reg  [7:0] rd_byte;
    wire       flags_read;
    wire [7:0] rise;

    ////////////////////////////////////////////////////////////////////////
    // One slip monitor per stage pair
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : pair
            mrfs_rate_mon #(
                .LVL_W    (LVL_W),
                .SLIP_LIM (SLIP_LIM),
                .SLIP_REL (SLIP_REL)
            ) u_mon (
                .aclk       (aclk),
                .aresetn    (aresetn),
                .recenter   (recenter_q),
                .in_stb     (stage_in_stb[g]),
                .out_stb    (stage_out_stb[g]),
                .overrun_q  (mon_ovr[g]),
                .underrun_q (mon_udr[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Live condition map, overrun above underrun for each pair
    assign cond[`MRFS_BIT_RX_STM0_OVR] = mon_ovr[3];
    assign cond[`MRFS_BIT_RX_STM0_UDR] = mon_udr[3];
    assign cond[`MRFS_BIT_TX_STM0_OVR] = mon_ovr[2];
    assign cond[`MRFS_BIT_TX_STM0_UDR] = mon_udr[2];
    assign cond[`MRFS_BIT_RX_DS3_OVR]  = mon_ovr[1];
    assign cond[`MRFS_BIT_RX_DS3_UDR]  = mon_udr[1];
    assign cond[`MRFS_BIT_TX_DS3_OVR]  = mon_ovr[0];
    assign cond[`MRFS_BIT_TX_DS3_UDR]  = mon_udr[0];

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order

    assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q     <= 1'b0;
            aw_idx_q      <= 6'h00;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q     <= 1'b1;
            aw_idx_q      <= mrfs_index(s_axi_awaddr);
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_hold_q     <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q     <= 1'b0;
            w_byte_q     <= 8'h00;
            w_lane0_q    <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q     <= 1'b1;
            w_byte_q     <= s_axi_wdata[7:0];
            w_lane0_q    <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_hold_q     <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // Response once both halves are in; unmapped gets a slave error
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `MRFS_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mrfs_mapped(aw_idx_q) ? `MRFS_RESP_OKAY : `MRFS_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Writable registers; conditions and flags have no write path
    always @(posedge aclk) begin
        if (!aresetn) begin
            enable_q <= `MRFS_RST_ENABLE;
        end else if (wr_fire && w_lane0_q && aw_idx_q == `MRFS_IDX_ENABLE) begin
            enable_q <= w_byte_q;
        end
    end

    // Recenter is a one-cycle command, self-clearing
    always @(posedge aclk) begin
        if (!aresetn) begin
            recenter_q <= 1'b0;
        end else begin
            recenter_q <= wr_fire && w_lane0_q && aw_idx_q == `MRFS_IDX_CTRL &&
                          w_byte_q[`MRFS_CTRL_RECENTER];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: data registered one cycle after the address is taken

    assign rd_fire    = s_axi_arvalid && s_axi_arready;
    assign rd_idx     = mrfs_index(s_axi_araddr);
    assign flags_read = rd_fire && rd_idx == `MRFS_IDX_FLAGS;

    always @* begin
        case (rd_idx)
            `MRFS_IDX_COND:   rd_byte = cond;
            `MRFS_IDX_FLAGS:  rd_byte = flags_q;
            `MRFS_IDX_ENABLE: rd_byte = enable_q;
            `MRFS_IDX_CTRL:   rd_byte = 8'h00;
            default:          rd_byte = 8'h00;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `MRFS_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= mrfs_mapped(rd_idx) ? `MRFS_RESP_OKAY : `MRFS_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latched flags: set on the declaring edge of an enabled condition,
    // cleared by the read that returns them. A set in the clearing cycle
    // survives, so an event never falls between read and clear.

    assign rise = cond & ~cond_prev_q;

    always @* begin
        flags_d = flags_q;
        if (flags_read) begin
            flags_d = 8'h00;
        end
        flags_d = flags_d | (rise & enable_q);
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            cond_prev_q <= 8'h00;
            flags_q     <= `MRFS_RST_FLAGS;
        end else begin
            cond_prev_q <= cond;
            flags_q     <= flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request from the next flag state, so it tracks flags_q
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags_d & enable_q);
        end
    end

endmodule

//--- shared/mrfs_defs.vh
`ifndef MRFS_DEFS_VH
`define MRFS_DEFS_VH

// Register indices; byte address is four times the index
`define MRFS_IDX_COND       6'h07
`define MRFS_IDX_FLAGS      6'h0B
`define MRFS_IDX_ENABLE     6'h0F
`define MRFS_IDX_CTRL       6'h10

// Condition and flag bit positions
`define MRFS_BIT_RX_STM0_OVR 7
`define MRFS_BIT_RX_STM0_UDR 6
`define MRFS_BIT_TX_STM0_OVR 5
`define MRFS_BIT_TX_STM0_UDR 4
`define MRFS_BIT_RX_DS3_OVR  3
`define MRFS_BIT_RX_DS3_UDR  2
`define MRFS_BIT_TX_DS3_OVR  1
`define MRFS_BIT_TX_DS3_UDR  0

// Control register fields
`define MRFS_CTRL_RECENTER  0

// Reset values
`define MRFS_RST_FLAGS      8'h00
`define MRFS_RST_ENABLE     8'h00

// Rate monitor defaults, in stage words of slip
`define MRFS_LVL_W          6
`define MRFS_SLIP_LIM       6'h18
`define MRFS_SLIP_REL       6'h08

// AXI responses
`define MRFS_RESP_OKAY      2'h0
`define MRFS_RESP_SLVERR    2'h2

`endif

//--- test/mrfs_checker.sv
`timescale 1ns/1ps
module mrfs_checker (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Decode of the read address, low two bits ignored
    wire [5:0] ridx = s_axi_araddr[7:2];
    wire       hit  = ridx == 6'h07 || ridx == 6'h0B || ridx == 6'h0F || ridx == 6'h10;
    ////////////////////////////////////////
    // Read steps: address taken, then data offered
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_rd_ans;
        s_rd_take ##1 s_axi_rvalid;
    endsequence
    ////////////////////////////////////////
    property p_rd_ans; s_rd_take |=> s_axi_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read not answered");
    property p_ar_block; s_rd_take |=> !s_axi_arready; endproperty
    a_ar_block: assert property (p_ar_block)
        else $error("second read accepted");
    property p_rd_byte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_rd_byte: assert property (p_rd_byte)
        else $error("upper read bits set");
    property p_rd_okay; s_rd_take ##0 hit |=> s_axi_rresp == 2'h0; endproperty
    a_rd_okay: assert property (p_rd_okay)
        else $error("mapped read refused");
    property p_rd_err; s_rd_take ##0 !hit |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    a_rd_err: assert property (p_rd_err)
        else $error("unmapped read not refused");
    // An asserted request means an enabled flag the read must show
    property p_irq_rd; irq && ridx == 6'h0B ##0 s_rd_ans |-> s_axi_rdata[7:0] != 8'h00;
    endproperty
    a_irq_rd: assert property (p_irq_rd)
        else $error("flags read empty while irq high");
    property p_irq_fall;
        $fell(irq) |-> $past(s_axi_arvalid && s_axi_arready)
            || $past(s_axi_wvalid && s_axi_wready, 2)
            || $past(s_axi_wvalid && s_axi_wready, 3);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped without access");
    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans)
        else $error("write not answered");
endmodule
bind mrfs_top mrfs_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .irq);

//--- test/test_mrfs_top.sv
`timescale 1ns/1ps
module test_mrfs_top;
    localparam [5:0] LIM    = 6'h04;
    localparam [7:0] A_COND = 8'h1C;
    localparam [7:0] A_FLAG = 8'h2C;
    localparam [7:0] A_EN   = 8'h3C;
    localparam [7:0] A_CTRL = 8'h40;
    reg         aclk;
    reg         aresetn;
    reg  [3:0]  stage_in_stb;
    reg  [3:0]  stage_out_stb;
    reg  [7:0]  s_axi_awaddr;
    reg         s_axi_awvalid;
    reg  [31:0] s_axi_wdata;
    reg         s_axi_wvalid;
    reg         s_axi_bready;
    reg  [7:0]  s_axi_araddr;
    reg         s_axi_arvalid;
    reg         s_axi_rready;
    wire        s_axi_awready;
    wire        s_axi_wready;
    wire [1:0]  s_axi_bresp;
    wire        s_axi_bvalid;
    wire        s_axi_arready;
    wire [31:0] s_axi_rdata;
    wire [1:0]  s_axi_rresp;
    wire        s_axi_rvalid;
    wire        irq;
    integer     bad_count;
    integer     total_checks;
    integer     cyc;
    integer     b;
    reg  [7:0]  en;
    reg  [31:0] rd;
    reg  [1:0]  rs;
    reg  [1:0]  ws;

    // Short slip limits keep each fault a few strobes away
    mrfs_top #(.SLIP_LIM(LIM), .SLIP_REL(6'h01)) u_dut (
        .aclk, .aresetn, .stage_in_stb, .stage_out_stb,
        .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
    );
    ////////////////////////////////////////
    // Free running clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // Hang guard, far above the five hundred cycles needed
    always @(posedge aclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            test_done;
        end
    end
    ////////////////////////////////////////
    function [1:0] exp_resp(input [7:0] a);
        exp_resp = (a == A_COND || a == A_FLAG || a == A_EN || a == A_CTRL) ? 2'h0 : 2'h2;
    endfunction
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("unexpected %s: expected %h, seen %h", nm, exp, got);
            end
        end
    endtask
    // Address and data offered together, each dropped once taken
    task axi_wr(input [7:0] a, input [7:0] d);
        reg aw;
        reg w;
        reg bd;
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            aw = 1'b1;
            w = 1'b1;
            bd = 1'b0;
            while (!bd) begin
                @(posedge aclk);
                if (aw && s_axi_awready) begin
                    aw = 1'b0;
                    s_axi_awvalid <= 1'b0;
                end
                if (w && s_axi_wready) begin
                    w = 1'b0;
                    s_axi_wvalid <= 1'b0;
                end
                if (s_axi_bvalid) begin
                    bd = 1'b1;
                    ws = s_axi_bresp;
                    s_axi_bready <= 1'b0;
                end
            end
        end
    endtask
    task axi_rd(input [7:0] a);
        reg ar;
        reg r;
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            ar = 1'b1;
            r = 1'b0;
            while (!r) begin
                @(posedge aclk);
                if (ar && s_axi_arready) begin
                    ar = 1'b0;
                    s_axi_arvalid <= 1'b0;
                end
                if (s_axi_rvalid) begin
                    r = 1'b1;
                    rd = s_axi_rdata;
                    rs = s_axi_rresp;
                    s_axi_rready <= 1'b0;
                end
            end
        end
    endtask
    task rchk(input [7:0] a, input [7:0] exp);
        begin
            axi_rd(a);
            chk("read data", {24'h0, exp}, rd);
            chk("read resp", {30'h0, exp_resp(a)}, {30'h0, rs});
        end
    endtask
    // Write, then hold the response code against the address map
    task wchk(input [7:0] a, input [7:0] d);
        begin
            axi_wr(a, d);
            chk("write resp", {30'h0, exp_resp(a)}, {30'h0, ws});
        end
    endtask
    // Back to back word strobes on one side of a stage pair
    task slip(input integer g, input up, input integer n);
        begin
            repeat (n) begin
                @(posedge aclk);
                if (up) stage_in_stb[g] <= 1'b1;
                else stage_out_stb[g] <= 1'b1;
            end
            @(posedge aclk);
            stage_in_stb <= 4'h0;
            stage_out_stb <= 4'h0;
            repeat (6) @(posedge aclk);
        end
    endtask
    task test_done;
        begin
            $display("checks %0d, mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    ////////////////////////////////////////
    initial begin
        {stage_in_stb, stage_out_stb, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        aresetn = 1'b0;
        bad_count = 0;
        total_checks = 0;
        cyc = 0;
        void'($urandom(32'h65ae));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(A_COND, 8'h00);
        rchk(A_FLAG, 8'h00);
        rchk(A_EN, 8'h00);
        rchk(8'h80, 8'h00);
        wchk(8'h80, 8'h00);
        wchk(A_COND, 8'hFF);
        rchk(A_COND, 8'h00);
        wchk(A_FLAG, 8'hFF);
        rchk(A_FLAG, 8'h00);
        // One fault per bit; odd bits overrun, even bits underrun
        for (b = 0; b < 8; b = b + 1) begin
            en = 8'($urandom);
            if (b == 0) en = 8'h00;
            if (b == 7) en = 8'hFF;
            wchk(A_EN, en);
            rchk(A_EN, en);
            slip(b / 2, b[0], LIM - 1);
            rchk(A_COND, 8'h00);
            slip(b / 2, b[0], 2);
            rchk(A_COND, 8'h01 << b);
            slip(b / 2, !b[0], 2);
            rchk(A_COND, 8'h01 << b);
            chk("irq", {31'h0, en[b]}, {31'h0, irq});
            rchk(A_FLAG, en & (8'h01 << b));
            chk("irq", 32'h0, {31'h0, irq});
            rchk(A_FLAG, 8'h00);
            wchk(A_CTRL, 8'h01);
            rchk(A_COND, 8'h00);
        end
        test_done;
    end
endmodule
